//--- core/adc_seq.sv
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "seq_map.svh"

module adc_seq import seq_pkg::*; #(
	parameter int POR_WAIT_NS = 250000,
	parameter int RESET_LOW_NS = 2000000
) (
	input wire logic sys_clk, // main clock
	input wire logic rst_n, // async reset
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic sync_or_reset_n, // sync/reset pin
	input wire logic data_read, // conversion data shifted out
	output logic data_ready_n, // data ready pin
	output logic modulator_enable, // modulators feed filters
	output logic fast_filter_active, // fast path selected
	output logic chop_polarity, // input polarity swapped
	output logic filter_reset, // digital filter reset pulse
	output logic ref_enable, // reference powered
	output logic osc_enable, // internal oscillator on
	output logic [1:0] power_mode_select, // power mode to analog
	output logic clock_source_select, // internal clock chosen
	output logic dc_test_enable // dc test signal routed
);

	localparam int POR_CYCLES = (POR_WAIT_NS + `SEQ_CLK_NS - 1) / `SEQ_CLK_NS;
	localparam int RST_CYCLES = (RESET_LOW_NS + `SEQ_CLK_NS - 1) / `SEQ_CLK_NS;

	ctrl_type ctrl_q, ctrl_d;
	logic aw_full_q, aw_full_d, w_full_q, w_full_d;
	logic [7:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic cmd_standby, cmd_wakeup, cmd_reset, soft_rst;

	seq_state_type state_q, state_d;
	logic [19:0] cnt_q, cnt_d, low_cnt_q, low_cnt_d;
	logic [1:0] samples_q, samples_d, osr_last_q, osr_last_d;
	logic data_ready_n_q, data_ready_n_d, pol_q, pol_d, first_q, first_d, frst_q, frst_d;
	logic chop_last_q, chop_last_d;
	logic sync_meta_q, sync_q, sync_last_q;
	logic sync_fall, conv_evt;
	logic [19:0] osr_w, dly_w, gc_w, period;

	// bus slave: address and data taken in either order
	always_comb begin
		logic do_wr;
		do_wr = 1'b0;
		aw_full_d = aw_full_q;
		w_full_d = w_full_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		ctrl_d = ctrl_q;
		cmd_standby = 1'b0;
		cmd_wakeup = 1'b0;
		cmd_reset = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_full_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_full_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		if (aw_full_q && w_full_q && !bvalid_q) begin
			do_wr = 1'b1;
			aw_full_d = 1'b0;
			w_full_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = `SEQ_RESP_OKAY;
		end
		if (s_axi_bvalid && s_axi_bready)
			bvalid_d = 1'b0;
		if (do_wr) begin
			if (awaddr_q[7:2] == `SEQ_CTRL_OFS >> 2) begin
				if (wstrb_q[0]) begin
					ctrl_d.chop_enable = wdata_q[`SEQ_CTRL_CHOP_BIT];
					ctrl_d.chop_delay_select = wdata_q[`SEQ_CTRL_DLY_LSB +: 4];
				end
				if (wstrb_q[1]) begin
					ctrl_d.power_mode_select = wdata_q[`SEQ_CTRL_PWR_LSB +: 2];
					ctrl_d.oversampling_ratio = wdata_q[`SEQ_CTRL_OSR_LSB +: 2];
				end
				if (wstrb_q[2]) begin
					ctrl_d.clock_source_select = wdata_q[`SEQ_CTRL_CLKSEL_BIT];
					ctrl_d.dc_test_req = wdata_q[`SEQ_CTRL_DCTEST_BIT];
				end
			end else if (awaddr_q[7:2] == `SEQ_CMD_OFS >> 2) begin
				cmd_standby = wstrb_q[0] && wdata_q[`SEQ_CMD_STANDBY_BIT];
				cmd_wakeup = wstrb_q[0] && wdata_q[`SEQ_CMD_WAKEUP_BIT];
				cmd_reset = wstrb_q[0] && wdata_q[`SEQ_CMD_RESET_BIT];
			end else if (awaddr_q[7:2] != `SEQ_STATUS_OFS >> 2) begin
				bresp_d = `SEQ_RESP_SLVERR;
			end
		end
		// device reset returns every setting, clock source included
		// external clock default
		if (soft_rst) begin
			ctrl_d = '0;
			ctrl_d.oversampling_ratio = `SEQ_CTRL_OSR_RST;
			ctrl_d.power_mode_select = `SEQ_CTRL_PWR_RST;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_d = 1'b1;
			rresp_d = `SEQ_RESP_OKAY;
			rdata_d = 32'h0;
			if (s_axi_araddr[7:2] == `SEQ_CTRL_OFS >> 2) begin
				rdata_d[`SEQ_CTRL_CHOP_BIT] = ctrl_q.chop_enable;
				rdata_d[`SEQ_CTRL_DLY_LSB +: 4] = ctrl_q.chop_delay_select;
				rdata_d[`SEQ_CTRL_PWR_LSB +: 2] = ctrl_q.power_mode_select;
				rdata_d[`SEQ_CTRL_OSR_LSB +: 2] = ctrl_q.oversampling_ratio;
				rdata_d[`SEQ_CTRL_CLKSEL_BIT] = ctrl_q.clock_source_select;
				rdata_d[`SEQ_CTRL_DCTEST_BIT] = ctrl_q.dc_test_req;
			end else if (s_axi_araddr[7:2] == `SEQ_STATUS_OFS >> 2) begin
				rdata_d[9:0] = {first_q, data_ready_n_q, pol_q, fast_filter_active,
					samples_q, 1'b0, state_q};
			end else if (s_axi_araddr[7:2] != `SEQ_CMD_OFS >> 2) begin
				rresp_d = `SEQ_RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= '{default: '0, oversampling_ratio: `SEQ_CTRL_OSR_RST,
				power_mode_select: `SEQ_CTRL_PWR_RST};
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= 2'h0;
			rvalid_q <= 1'b0;
			rresp_q <= 2'h0;
			rdata_q <= 32'h0;
		end else begin
			ctrl_q <= ctrl_d;
			aw_full_q <= aw_full_d;
			w_full_q <= w_full_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
		end
	end

	assign s_axi_awready = !aw_full_q && !bvalid_q;
	assign s_axi_wready = !w_full_q && !bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;

	// pin synchroniser
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_meta_q <= 1'b1;
			sync_q <= 1'b1;
			sync_last_q <= 1'b1;
		end else begin
			sync_meta_q <= sync_or_reset_n;
			sync_q <= sync_meta_q;
			sync_last_q <= sync_q;
		end
	end
	assign sync_fall = sync_last_q && !sync_q;

	// delay from 2 to 65536 periods
	assign dly_w = `SEQ_DLY_BASE << ctrl_q.chop_delay_select;
	assign osr_w = `SEQ_OSR_BASE << ctrl_q.oversampling_ratio;
	assign gc_w = 20'(dly_w + osr_w * `SEQ_GC_FACTOR);
	always_comb begin
		if (!ctrl_q.chop_enable)
			period = osr_w;
		else if (first_q)
			period = 20'((gc_w << 1) + `SEQ_FIRST_EXTRA);
		else
			period = gc_w;
	end
	// compare with >= so that a shorter period set mid-count still ends the conversion
	assign conv_evt = (state_q == ST_RUN) && (cnt_q >= period - 20'h1);
	assign soft_rst = cmd_reset || (state_q == ST_HOLD);

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		samples_d = samples_q;
		data_ready_n_d = data_ready_n_q;
		pol_d = pol_q;
		first_d = first_q;
		frst_d = 1'b0;
		osr_last_d = ctrl_q.oversampling_ratio;
		chop_last_d = ctrl_q.chop_enable;
		low_cnt_d = sync_q ? 20'h0 : low_cnt_q + ((low_cnt_q == 20'hFFFFF) ? 20'h0 : 20'h1);
		unique case (state_q)
			ST_POR: begin
				data_ready_n_d = 1'b0;
				cnt_d = cnt_q + 20'h1;
				if (cnt_q == 20'(POR_CYCLES - 1)) begin
					state_d = ST_INIT;
					cnt_d = 20'h0;
				end
			end
			ST_INIT: begin
				data_ready_n_d = 1'b1;
				cnt_d = cnt_q + 20'h1;
				if (cnt_q == 20'(`SEQ_INIT_WAIT - 1)) begin
					state_d = ST_RUN;
					cnt_d = 20'h0;
					samples_d = 2'h0;
					first_d = 1'b1;
					pol_d = 1'b0;
					frst_d = 1'b1;
				end
			end
			ST_RUN: begin
				if (cmd_standby) begin
					state_d = ST_STBY;
				end else if (ctrl_q.chop_enable && (sync_fall
						|| osr_last_q != ctrl_q.oversampling_ratio || !chop_last_q)) begin
					cnt_d = 20'h0;
					first_d = 1'b1;
					pol_d = 1'b0;
					frst_d = 1'b1;
				end else if (sync_fall && cnt_q != 20'h0) begin
					cnt_d = 20'h0;
					frst_d = 1'b1;
				end else if (conv_evt) begin
					data_ready_n_d = 1'b0;
					cnt_d = 20'h0;
					first_d = 1'b0;
					if (samples_q != 2'h3)
						samples_d = samples_q + 2'h1;
					if (ctrl_q.chop_enable) begin
						pol_d = !pol_q;
						frst_d = 1'b1;
					end
				end else begin
					cnt_d = cnt_q + 20'h1;
					if (data_read || cnt_q == period - 20'h2)
						data_ready_n_d = 1'b1;
				end
			end
			ST_STBY: begin
				if (cmd_wakeup) begin
					state_d = ST_RUN;
					cnt_d = 20'h0;
					samples_d = 2'h0;
					first_d = 1'b1;
					pol_d = 1'b0;
					frst_d = 1'b1;
				end
			end
			ST_HOLD: begin
				data_ready_n_d = 1'b0;
				if (sync_q) begin
					state_d = ST_INIT;
					cnt_d = 20'h0;
				end
			end
		endcase
		if (cmd_reset && state_q != ST_POR) begin
			state_d = ST_INIT;
			cnt_d = 20'h0;
			data_ready_n_d = 1'b0;
		end
		if (!sync_q && low_cnt_q >= 20'(RST_CYCLES)) begin
			state_d = ST_HOLD;
			cnt_d = 20'h0;
			data_ready_n_d = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_POR;
			cnt_q <= 20'h0;
			low_cnt_q <= 20'h0;
			samples_q <= 2'h0;
			data_ready_n_q <= 1'b0;
			pol_q <= 1'b0;
			first_q <= 1'b1;
			frst_q <= 1'b0;
			osr_last_q <= `SEQ_CTRL_OSR_RST;
			chop_last_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			low_cnt_q <= low_cnt_d;
			samples_q <= samples_d;
			data_ready_n_q <= data_ready_n_d;
			pol_q <= pol_d;
			first_q <= first_d;
			frst_q <= frst_d;
			osr_last_q <= osr_last_d;
			chop_last_q <= chop_last_d;
		end
	end

	assign data_ready_n = data_ready_n_q;
	assign modulator_enable = (state_q == ST_RUN);
	// fast path for first two samples
	assign fast_filter_active = modulator_enable && samples_q < `SEQ_FAST_SAMPLES;
	assign chop_polarity = pol_q;
	assign filter_reset = frst_q;
	assign ref_enable = (state_q != ST_STBY);
	assign osc_enable = (state_q != ST_STBY) && ctrl_q.clock_source_select;
	// power mode passed through in both modes
	assign power_mode_select = ctrl_q.power_mode_select;
	assign clock_source_select = ctrl_q.clock_source_select;
	assign dc_test_enable = ctrl_q.dc_test_req && !ctrl_q.chop_enable;

	chk_por_data_ready_n_rise: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state_q == ST_POR) ##1 (state_q == ST_INIT) |=> data_ready_n)
		else $error("data ready did not rise after power-on wait");
	chk_init_no_mod: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(modulator_enable) && $past(state_q) == ST_INIT
		|-> $past(cnt_q) == 20'(`SEQ_INIT_WAIT - 1))
		else $error("modulators started before initial wait");
	chk_fast_two: assert property (@(posedge sys_clk) disable iff (!rst_n)
		modulator_enable && $past(modulator_enable) && $fell(fast_filter_active)
		|-> $past(conv_evt) && samples_q == 2'h2)
		else $error("fast filter left at wrong sample");
	chk_data_ready_n_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$fell(data_ready_n) && state_q == ST_RUN |-> $past(conv_evt))
		else $error("data ready fell without a conversion");
	chk_chop_swap: assert property (@(posedge sys_clk) disable iff (!rst_n)
		conv_evt && ctrl_q.chop_enable && !cmd_standby && !cmd_reset && sync_q
		&& !sync_fall && chop_last_q && osr_last_q == ctrl_q.oversampling_ratio
		|=> chop_polarity != $past(chop_polarity) && filter_reset)
		else $error("polarity swap or filter reset missing");
	chk_chop_restart: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_q == ST_RUN && ctrl_q.chop_enable && sync_fall && !cmd_standby
		&& !cmd_reset && low_cnt_q < 20'(RST_CYCLES) |=> cnt_q == 20'h0 && first_q)
		else $error("chop not restarted on sync fall");
	chk_stby_power: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_q == ST_STBY |-> !ref_enable && !osc_enable && !modulator_enable)
		else $error("standby left circuitry powered");
	chk_stby_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_q == ST_STBY ##1 state_q == ST_STBY |-> !$fell(data_ready_n))
		else $error("data ready fell during standby");
	chk_dc_chop: assert property (@(posedge sys_clk) disable iff (!rst_n)
		ctrl_q.chop_enable |-> !dc_test_enable)
		else $error("dc test enabled in chop mode");
	chk_hold_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_q == ST_HOLD && !sync_q |=> state_q == ST_HOLD && !data_ready_n)
		else $error("pin reset released while pin low");

	cov_third_sample: cover property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(samples_q == 2'h3));
	cov_chop_conv: cover property (@(posedge sys_clk) disable iff (!rst_n)
		conv_evt && ctrl_q.chop_enable);
	cov_wakeup: cover property (@(posedge sys_clk) disable iff (!rst_n)
		state_q == ST_STBY ##1 state_q == ST_RUN);

endmodule

//--- core/seq_map.svh
`ifndef SEQ_MAP_SVH
`define SEQ_MAP_SVH

// register byte offsets
`define SEQ_CTRL_OFS 8'h00
`define SEQ_CMD_OFS 8'h04
`define SEQ_STATUS_OFS 8'h08

// control register fields
`define SEQ_CTRL_CHOP_BIT 0
`define SEQ_CTRL_DLY_LSB 4
`define SEQ_CTRL_PWR_LSB 8
`define SEQ_CTRL_OSR_LSB 12
`define SEQ_CTRL_CLKSEL_BIT 16
`define SEQ_CTRL_DCTEST_BIT 17
`define SEQ_CTRL_OSR_RST 2'h3
`define SEQ_CTRL_PWR_RST 2'h0

// command register bits
`define SEQ_CMD_STANDBY_BIT 0
`define SEQ_CMD_WAKEUP_BIT 1
`define SEQ_CMD_RESET_BIT 2

// timing, in modulator periods (one per clock); SEQ_CLK_NS is the clock period in ns
`define SEQ_CLK_NS 40
`define SEQ_INIT_WAIT (256 + 44)
`define SEQ_FIRST_EXTRA 44
`define SEQ_GC_FACTOR 3
`define SEQ_OSR_BASE 20'h00080
`define SEQ_DLY_BASE 20'h00002
`define SEQ_FAST_SAMPLES 2

`define SEQ_RESP_OKAY 2'h0
`define SEQ_RESP_SLVERR 2'h2

`endif

//--- core/seq_pkg.sv
package seq_pkg;

	typedef enum logic [2:0] {
		ST_POR = 3'h0,
		ST_INIT = 3'h1,
		ST_RUN = 3'h3,
		ST_STBY = 3'h2,
		ST_HOLD = 3'h6
	} seq_state_type;

	typedef struct packed {
		logic dc_test_req;
		logic clock_source_select;
		logic [1:0] oversampling_ratio;
		logic [1:0] power_mode_select;
		logic [3:0] chop_delay_select;
		logic chop_enable;
	} ctrl_type;

endpackage

//--- dv/host_model.sv
`timescale 1ns/1ps
module host_model (
	input wire logic sys_clk, // main clock
	input wire logic rst_n, // reset
	input wire logic data_ready_n, // data ready from device
	input wire logic read_en, // fetch each conversion
	input wire logic sync_go, // start a low pulse
	input wire logic [7:0] sync_len, // pulse length in clocks
	output logic sync_or_reset_n, // sync or reset pin
	output logic data_read // conversion fully shifted out
);
	logic [3:0] wait_q;
	logic [3:0] wait_d;
	logic [7:0] low_q;
	logic [7:0] low_d;

	always_comb begin
		low_d = low_q;
		if (low_q != 8'h00) begin
			low_d = low_q - 8'h01;
		end else if (sync_go) begin
			low_d = sync_len;
		end
		wait_d = 4'h0;
		if (!data_ready_n && read_en && wait_q != 4'h8) begin
			wait_d = wait_q + 4'h1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			low_q <= 8'h00;
			wait_q <= 4'h0;
		end else begin
			low_q <= low_d;
			wait_q <= wait_d;
		end
	end

	assign sync_or_reset_n = (low_q == 8'h00);
	assign data_read = (wait_q == 4'h8);
endmodule

//--- dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import seq_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic awvalid = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic [7:0] araddr = 8'h00;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic read_en = 1'b1;
	logic sync_go = 1'b0;
	logic [7:0] sync_len = 8'h04;
	logic awready, wready, bvalid, arready, rvalid, sync_or_reset_n, data_read;
	logic [1:0] bresp, rresp, power_mode_select;
	logic [31:0] rdata;
	logic data_ready_n, modulator_enable, fast_filter_active, chop_polarity, filter_reset;
	logic ref_enable, osc_enable, clock_source_select, dc_test_enable;
	logic data_ready_n_p = 1'b0;
	logic mod_p = 1'b0;
	logic sync_p = 1'b1;
	longint cyc = 0;
	longint fall_t = 0;
	longint rise_t = 0;
	longint mod_t = 0;
	longint sync_t = 0;
	int nfall = 0;
	int nfrst = 0;
	int num_errors = 0;
	int compares = 0;

	always #20 sys_clk = ~sys_clk;

	adc_seq #(.POR_WAIT_NS(400), .RESET_LOW_NS(4000)) adc_seq_inst (
		.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.sync_or_reset_n(sync_or_reset_n), .data_read(data_read),
		.data_ready_n(data_ready_n), .modulator_enable(modulator_enable),
		.fast_filter_active(fast_filter_active), .chop_polarity(chop_polarity),
		.filter_reset(filter_reset), .ref_enable(ref_enable), .osc_enable(osc_enable),
		.power_mode_select(power_mode_select), .clock_source_select(clock_source_select),
		.dc_test_enable(dc_test_enable));

	host_model host_model_inst (.sys_clk(sys_clk), .rst_n(rst_n),
		.data_ready_n(data_ready_n), .read_en(read_en), .sync_go(sync_go),
		.sync_len(sync_len), .sync_or_reset_n(sync_or_reset_n), .data_read(data_read));

	// edge and pulse timestamps
	always @(posedge sys_clk) begin
		cyc++;
		if (data_ready_n_p === 1'b1 && data_ready_n === 1'b0) begin
			nfall++;
			fall_t = cyc;
		end
		if (data_ready_n_p === 1'b0 && data_ready_n === 1'b1) rise_t = cyc;
		if (mod_p === 1'b0 && modulator_enable === 1'b1) mod_t = cyc;
		if (sync_p === 1'b1 && sync_or_reset_n === 1'b0) sync_t = cyc;
		if (filter_reset === 1'b1) nfrst++;
		data_ready_n_p = data_ready_n;
		mod_p = modulator_enable;
		sync_p = sync_or_reset_n;
	end

	task automatic complete_run;
		if (num_errors == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_range(input longint got, input longint lo, input longint hi);
		compares++;
		if (got < lo || got > hi) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 300);
		bready <= 1'b0;
		r = bresp;
		if (n >= 300) num_errors++;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 300);
		rready <= 1'b0;
		d = rdata;
		r = rresp;
		if (n >= 300) num_errors++;
	endtask

	task automatic wait_fall(output longint t);
		int n0;
		int k;
		n0 = nfall;
		k = 0;
		while (nfall == n0 && k < 5000) begin
			step(1);
			k++;
		end
		if (nfall == n0) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, nfall, n0 + 1);
		end
		t = fall_t;
	endtask

	task automatic sync_pulse(input logic [7:0] len);
		@(posedge sys_clk);
		sync_len <= len;
		sync_go <= 1'b1;
		@(posedge sys_clk);
		sync_go <= 1'b0;
	endtask

	initial begin
		repeat (40000) @(posedge sys_clk);
		num_errors++;
		complete_run();
	end

	initial begin
		logic [1:0] r;
		logic [31:0] d;
		logic pol;
		longint t0, t1, t2, t3;
		int f0;
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		step(1);
		t0 = cyc;
		step(4);
		cmp(data_ready_n, 1'b0);
		wait_fall(t1);
		cmp_range(rise_t - t0, 10, 13);
		cmp_range(mod_t - rise_t, 299, 301);
		cmp_range(t1 - rise_t, 1323, 1326);
		cmp(fast_filter_active, 1'b1);
		cmp(modulator_enable, 1'b1);
		step(12);
		cmp(data_ready_n, 1'b1);
		wait_fall(t2);
		cmp(fast_filter_active, 1'b0);
		cmp_range(t2 - t1, 1024, 1024);
		// register map, defaults and unmapped offsets
		axi_rd(8'h00, d, r);
		cmp(d, 32'h0000_3000);
		axi_rd(8'h0C, d, r);
		cmp(d, 32'h0);
		cmp(r, 2'h2);
		axi_wr(8'h0C, 32'h0000_0001, r);
		cmp(r, 2'h2);
		for (int i = 0; i < 3; i++) begin
			axi_wr(8'h00, 32'h0000_3000 | (i << 8), r);
			step(2);
			cmp(power_mode_select, i[1:0]);
		end
		axi_wr(8'h00, 32'h0001_3000, r);
		step(2);
		cmp({clock_source_select, osc_enable}, 2'h3);
		axi_wr(8'h04, 32'h0000_0004, r);
		step(2);
		cmp(clock_source_select, 1'b0);
		axi_wr(8'h00, 32'h0001_3000, r);
		wait_fall(t1);
		cmp_range(mod_t - rise_t, 299, 301);
		cmp_range(t1 - rise_t, 1323, 1326);
		cmp({fast_filter_active, clock_source_select}, 2'h3);
		// continuous mode at the shortest ratio
		axi_wr(8'h00, 32'h0000_0000, r);
		wait_fall(t1);
		wait_fall(t1);
		wait_fall(t2);
		cmp_range(t2 - t1, 128, 128);
		step(50);
		f0 = nfrst;
		sync_pulse(8'h04);
		step(8);
		cmp(nfrst > f0, 1'b1);
		wait_fall(t1);
		cmp_range(t1 - sync_t, 128, 134);
		// global chop, sync restart then steady periods
		axi_wr(8'h00, 32'h0000_0001, r);
		step(20);
		sync_pulse(8'h04);
		wait_fall(t1);
		cmp_range(t1 - sync_t, 816, 822);
		pol = chop_polarity;
		f0 = nfrst;
		wait_fall(t2);
		cmp_range(t2 - t1, 386, 386);
		cmp(chop_polarity, !pol);
		cmp(nfrst > f0, 1'b1);
		axi_wr(8'h00, 32'h0000_1001, r);
		t0 = cyc;
		wait_fall(t1);
		cmp_range(t1 - t0, 1580, 1586);
		axi_wr(8'h00, 32'h0002_1031, r);
		step(2);
		cmp(dc_test_enable, 1'b0);
		wait_fall(t1);
		wait_fall(t2);
		wait_fall(t3);
		cmp_range(t3 - t2, 784, 784);
		axi_wr(8'h00, 32'h0002_0000, r);
		step(2);
		cmp(dc_test_enable, 1'b1);
		// standby keeps registers, wakeup resumes
		axi_wr(8'h04, 32'h0000_0001, r);
		step(2);
		cmp({ref_enable, osc_enable}, 2'h0);
		f0 = nfall;
		step(600);
		cmp(nfall, f0);
		axi_rd(8'h00, d, r);
		cmp(d, 32'h0002_0000);
		axi_wr(8'h04, 32'h0000_0002, r);
		step(2);
		cmp(ref_enable, 1'b1);
		wait_fall(t1);
		// long low on the pin resets
		sync_pulse(8'h96);
		step(130);
		cmp({data_ready_n, modulator_enable}, 2'h0);
		step(30);
		cmp(data_ready_n, 1'b1);
		axi_rd(8'h00, d, r);
		cmp(d, 32'h0000_3000);
		complete_run();
	end
endmodule
